// ===== bvp_pkg.sv
// constants for the buck voltage and page control register bank
// assumes a single system clock; no timing constants are needed here
package bvp_pkg;

  // widths
  localparam int ADDR_W = 10;
  localparam int CODE_W = 7;
  localparam int MV_W   = 11;

  // full register addresses after page mapping
  localparam logic [9:0] OFS_CONF_A  = 10'h0D1;
  localparam logic [9:0] OFS_CONF_B  = 10'h0D2;
  localparam logic [9:0] OFS_LIM_A   = 10'h0D5;
  localparam logic [9:0] OFS_LIM_B   = 10'h0D6;
  localparam logic [9:0] OFS_SET_A1  = 10'h0D7;
  localparam logic [9:0] OFS_SET_A2  = 10'h0D8;
  localparam logic [9:0] OFS_SET_B1  = 10'h0D9;
  localparam logic [9:0] OFS_SET_B2  = 10'h0DA;
  localparam logic [9:0] OFS_PAGE    = 10'h100;

  // page window bases
  localparam logic [9:0] BASE_LOW    = 10'h000;
  localparam logic [9:0] BASE_HIGH   = 10'h080;
  localparam logic [9:0] BASE_P2     = 10'h100;
  localparam logic [9:0] BASE_P4     = 10'h200;

  // page select codes, four-wire (full) and two-wire (bits 2:1)
  localparam logic [2:0] PG4_LOW     = 3'h0;
  localparam logic [2:0] PG4_HIGH    = 3'h1;
  localparam logic [2:0] PG4_P2      = 3'h2;
  localparam logic [2:0] PG4_P4      = 3'h4;
  localparam logic [1:0] PG2_LOW     = 2'h0;
  localparam logic [1:0] PG2_P2      = 2'h1;
  localparam logic [1:0] PG2_P4      = 2'h2;

  // field positions
  localparam int MODE_BIT   = 7;
  localparam int PAGE_AUTO_RETURN_BIT = 7;
  localparam int WMODE_BIT  = 6;
  localparam int PAGE_MSB   = 2;
  localparam int OPM_MSB    = 1;

  // operating mode field encodings
  localparam logic [1:0] OPM_BY_SET  = 2'h0;
  localparam logic [1:0] OPM_AUTO1   = 2'h1;
  localparam logic [1:0] OPM_PWM     = 2'h2;
  localparam logic [1:0] OPM_AUTO    = 2'h3;

  // reset values
  localparam logic [7:0] RST_SETTING = 8'h00;
  localparam logic [2:0] RST_PAGE    = 3'h0;
  localparam logic [1:0] RST_OPM     = 2'h0;
  localparam logic [6:0] RST_LIMIT   = 7'h00;
  localparam logic [7:0] RD_ZERO     = 8'h00;

  // voltage scale: code 0 is 300 mV, 10 mV per step
  localparam logic [10:0] VMIN_MV    = 11'h12C;
  localparam logic [3:0]  STEP_MV    = 4'hA;

endpackage : bvp_pkg

// ===== bvp_page_map.sv
// page mapping from an in-page serial address to a full register address
// assumes page and interface type are stable during an access
`timescale 1ns/1ps
`default_nettype none

module bvp_page_map
  import bvp_pkg::*;
(
  // page selection
  input  wire logic [2:0]        page_in,
  input  wire logic              four_wire_in,
  // in-page address from the serial engine
  input  wire logic [7:0]        addr_in,
  // mapped address
  output logic      [ADDR_W-1:0] full_addr_out,
  output logic                   hit_out
);

  // offset inside one 128-register window
  logic [ADDR_W-1:0] win_ofs;
  assign win_ofs = {3'h0, addr_in[6:0]};

  // two-wire: bit 0 of the page is ignored, pages 2 and 4 are half size
  logic [ADDR_W-1:0] tw_addr;
  logic              tw_hit;
  assign tw_addr = (page_in[2:1] == PG2_LOW) ? {2'h0, addr_in} :
                   (page_in[2:1] == PG2_P2)  ? (BASE_P2 | win_ofs) :
                                               (BASE_P4 | win_ofs);
  assign tw_hit  = (page_in[2:1] == PG2_LOW) ||
                   (((page_in[2:1] == PG2_P2) || (page_in[2:1] == PG2_P4))
                    && !addr_in[7]);

  // four-wire: seven address bits, each page one 128-register window
  logic [ADDR_W-1:0] fw_base;
  logic              fw_hit;
  assign fw_base = (page_in == PG4_HIGH) ? BASE_HIGH :
                   (page_in == PG4_P2)   ? BASE_P2 :
                   (page_in == PG4_P4)   ? BASE_P4 : BASE_LOW;
  assign fw_hit  = (page_in == PG4_LOW) || (page_in == PG4_HIGH) ||
                   (page_in == PG4_P2)  || (page_in == PG4_P4);

  assign full_addr_out = four_wire_in ? (fw_base | win_ofs)
                                      : tw_addr;
  assign hit_out       = four_wire_in ? fw_hit : tw_hit;

endmodule // bvp_page_map

`default_nettype wire

// ===== bvp_regs.sv
// buck voltage settings, factory limits and page control register bank
// assumes a serial engine that hands over byte accesses and an end strobe
//
// Summary of operation
// - codes are 300 mV plus 10 mV per step; buck B clamps to limit
// - buck B limit read-only, factory loaded, readable in test mode
// - buck A setting bit 7: 0 forces PWM, 1 automatic while selected
// - buck B setting bit 7: 0 forces PWM, 1 automatic while selected
// - with page return set, page field clears when a transaction ends
// - write-mode bit: 0 page write, 1 repeated write for two-wire
// - two-wire pages 00x, 01x, 10x map to 0x000, 0x100, 0x200 windows
// - four-wire pages 000, 001, 010, 100 map to 128-register windows
// - op mode 00 takes PWM or auto from the selected setting's bit
// - buck A also has a read-only factory limit and clamps to it
`timescale 1ns/1ps
`default_nettype none

module bvp_regs
  import bvp_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              nrst_in,
  // serial engine access port
  input  wire logic              four_wire_in,
  input  wire logic [7:0]        addr_in,
  input  wire logic              wr_en_in,
  input  wire logic [7:0]        wr_data_in,
  input  wire logic              rd_en_in,
  input  wire logic              xfer_done_in,
  output logic      [7:0]        rd_data_out,
  output logic                   rd_valid_out,
  output logic      [2:0]        page_sel_out,
  output logic                   write_mode_out,
  // factory storage and test mode
  input  wire logic [CODE_W-1:0] otp_limit_a_in,
  input  wire logic [CODE_W-1:0] otp_limit_b_in,
  input  wire logic              test_mode_in,
  // voltage selection (dynamic voltage control)
  input  wire logic              buck_a_sel_two_in,
  input  wire logic              buck_b_sel_two_in,
  // regulator side
  output logic      [CODE_W-1:0] buck_a_vcode_out,
  output logic                   buck_a_auto_out,
  output logic      [MV_W-1:0]   buck_a_mv_out,
  output logic      [CODE_W-1:0] buck_b_vcode_out,
  output logic                   buck_b_auto_out,
  output logic      [MV_W-1:0]   buck_b_mv_out
);

  // clamp a requested code to the factory ceiling
  function automatic logic [CODE_W-1:0] clamp_code(
    input logic [CODE_W-1:0] code,
    input logic [CODE_W-1:0] limit);
    clamp_code = (code > limit) ? limit : code;
  endfunction

  // millivolt figure of a code
  function automatic logic [MV_W-1:0] code_to_mv(
    input logic [CODE_W-1:0] code);
    // widen before the product, a 7-bit product would wrap high codes
    code_to_mv = VMIN_MV + MV_W'(code) * MV_W'(STEP_MV);
  endfunction

  // pwm or automatic from the op mode field and selected setting bit
  function automatic logic pick_auto(
    input logic [1:0] opm,
    input logic       set_bit);
    case (opm)
      OPM_BY_SET: pick_auto = set_bit;
      OPM_PWM:    pick_auto = 1'b0;
      default:    pick_auto = 1'b1;
    endcase
  endfunction

  // reset synchroniser: async assert, two-flop release
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // register state
  logic [7:0]        set_a1_r, set_a2_r, set_b1_r, set_b2_r;
  logic [1:0]        opm_a_r, opm_b_r;
  logic [2:0]        page_r;
  logic              page_auto_return_r, wmode_r;
  logic [CODE_W-1:0] lim_a_r, lim_b_r;
  logic              lim_loaded_r;

  // address mapping through the current page
  logic [ADDR_W-1:0] full_addr;
  logic              addr_hit;
  bvp_page_map u_page_map (
    .page_in       (page_r),
    .four_wire_in  (four_wire_in),
    .addr_in       (addr_in),
    .full_addr_out (full_addr),
    .hit_out       (addr_hit)
  );

  // write decode
  wire wr_ok     = wr_en_in && addr_hit;
  wire wr_set_a1 = wr_ok && (full_addr == OFS_SET_A1);
  wire wr_set_a2 = wr_ok && (full_addr == OFS_SET_A2);
  wire wr_set_b1 = wr_ok && (full_addr == OFS_SET_B1);
  wire wr_set_b2 = wr_ok && (full_addr == OFS_SET_B2);
  wire wr_conf_a = wr_ok && (full_addr == OFS_CONF_A);
  wire wr_conf_b = wr_ok && (full_addr == OFS_CONF_B);
  // page control answers at the base of every window, otherwise the
  // host could never leave page 0; no other register sits there
  wire at_page   = (full_addr == BASE_LOW) || (full_addr == BASE_HIGH) ||
                   (full_addr == OFS_PAGE) || (full_addr == BASE_P4);
  wire wr_page   = wr_ok && at_page;

  // settings and op mode registers
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      set_a1_r <= RST_SETTING;
      set_a2_r <= RST_SETTING;
      set_b1_r <= RST_SETTING;
      set_b2_r <= RST_SETTING;
      opm_a_r  <= RST_OPM;
      opm_b_r  <= RST_OPM;
    end else begin
      if (wr_set_a1) set_a1_r <= wr_data_in;
      if (wr_set_a2) set_a2_r <= wr_data_in;
      if (wr_set_b1) set_b1_r <= wr_data_in;
      if (wr_set_b2) set_b2_r <= wr_data_in;
      if (wr_conf_a) opm_a_r  <= wr_data_in[OPM_MSB:0];
      if (wr_conf_b) opm_b_r  <= wr_data_in[OPM_MSB:0];
    end
  end

  // page control next value; the end strobe clears the page after any
  // write in the same cycle, so a final write that sets the return bit
  // still lands the host back on the low page
  logic       page_auto_return_nxt;
  logic       wmode_nxt;
  logic [2:0] page_nxt;
  assign page_auto_return_nxt = wr_page ? wr_data_in[PAGE_AUTO_RETURN_BIT] : page_auto_return_r;
  assign wmode_nxt  = wr_page ? wr_data_in[WMODE_BIT]  : wmode_r;
  assign page_nxt   = (xfer_done_in && page_auto_return_nxt) ? RST_PAGE :
                      wr_page ? wr_data_in[PAGE_MSB:0] : page_r;

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      page_r   <= RST_PAGE;
      page_auto_return_r <= 1'b0;
      wmode_r  <= 1'b0;
    end else begin
      page_r   <= page_nxt;
      page_auto_return_r <= page_auto_return_nxt;
      wmode_r  <= wmode_nxt;
    end
  end

  // factory limits caught once after reset release; the reset itself
  // only loads a constant, storage outputs are sampled by the clock
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lim_a_r      <= RST_LIMIT;
      lim_b_r      <= RST_LIMIT;
      lim_loaded_r <= 1'b0;
    end else if (!lim_loaded_r) begin
      lim_a_r      <= otp_limit_a_in;
      lim_b_r      <= otp_limit_b_in;
      lim_loaded_r <= 1'b1;
    end
  end

  // read decode; limits show only in test mode, reserved bits read zero
  logic [7:0] rd_mux;
  assign rd_mux =
    !addr_hit                 ? RD_ZERO :
    (full_addr == OFS_SET_A1) ? set_a1_r :
    (full_addr == OFS_SET_A2) ? set_a2_r :
    (full_addr == OFS_SET_B1) ? set_b1_r :
    (full_addr == OFS_SET_B2) ? set_b2_r :
    (full_addr == OFS_CONF_A) ? {6'h00, opm_a_r} :
    (full_addr == OFS_CONF_B) ? {6'h00, opm_b_r} :
    at_page                   ? {page_auto_return_r, wmode_r, 3'h0, page_r} :
    (full_addr == OFS_LIM_A && test_mode_in) ? {1'b0, lim_a_r} :
    (full_addr == OFS_LIM_B && test_mode_in) ? {1'b0, lim_b_r} :
    RD_ZERO;

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_out  <= RD_ZERO;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) rd_data_out <= rd_mux;
    end
  end

  // selected setting per buck, clamped and turned into a mode
  logic [7:0]        sel_a, sel_b;
  logic [CODE_W-1:0] code_a_nxt, code_b_nxt;
  logic              auto_a_nxt, auto_b_nxt;
  assign sel_a      = buck_a_sel_two_in ? set_a2_r : set_a1_r;
  assign sel_b      = buck_b_sel_two_in ? set_b2_r : set_b1_r;
  assign code_a_nxt = clamp_code(sel_a[CODE_W-1:0], lim_a_r);
  assign code_b_nxt = clamp_code(sel_b[CODE_W-1:0], lim_b_r);
  assign auto_a_nxt = pick_auto(opm_a_r, sel_a[MODE_BIT]);
  assign auto_b_nxt = pick_auto(opm_b_r, sel_b[MODE_BIT]);

  // regulator outputs, registered one cycle after the selection moves
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      buck_a_vcode_out <= RST_LIMIT;
      buck_b_vcode_out <= RST_LIMIT;
      buck_a_auto_out  <= 1'b0;
      buck_b_auto_out  <= 1'b0;
      buck_a_mv_out    <= VMIN_MV;
      buck_b_mv_out    <= VMIN_MV;
    end else begin
      buck_a_vcode_out <= code_a_nxt;
      buck_b_vcode_out <= code_b_nxt;
      buck_a_auto_out  <= auto_a_nxt;
      buck_b_auto_out  <= auto_b_nxt;
      buck_a_mv_out    <= code_to_mv(code_a_nxt);
      buck_b_mv_out    <= code_to_mv(code_b_nxt);
    end
  end

  // page control fields seen by the serial engine
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      page_sel_out   <= RST_PAGE;
      write_mode_out <= 1'b0;
    end else begin
      page_sel_out   <= page_nxt;
      write_mode_out <= wmode_nxt;
    end
  end

  // checks
  page_return_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    xfer_done_in && page_auto_return_nxt
    |=> page_r == RST_PAGE && page_sel_out == RST_PAGE)
    else $error("page not returned after transaction");

  write_mode_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    wr_page |=> write_mode_out == $past(wr_data_in[WMODE_BIT]))
    else $error("write mode bit not taken");

  // scale recomputed at full width so that high codes cannot wrap
  clamp_b_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    lim_loaded_r |=> buck_b_vcode_out <= lim_b_r &&
      buck_b_mv_out == VMIN_MV + MV_W'(buck_b_vcode_out) * MV_W'(STEP_MV))
    else $error("buck b code above limit or wrong scale");

  clamp_a_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    lim_loaded_r |=> buck_a_vcode_out <= lim_a_r)
    else $error("buck a code above limit");

  limit_hidden_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    rd_en_in && !test_mode_in && addr_hit && full_addr == OFS_LIM_B
    |=> rd_valid_out && rd_data_out == RD_ZERO)
    else $error("limit readable outside test mode");

  limit_fixed_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    lim_loaded_r |=> $stable(lim_b_r) && $stable(lim_a_r))
    else $error("factory limit changed");

  mode_a_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    opm_a_r == OPM_BY_SET && !buck_a_sel_two_in
    |=> buck_a_auto_out == $past(set_a1_r[MODE_BIT]))
    else $error("buck a mode not from setting one");

  mode_b_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    opm_b_r == OPM_BY_SET && buck_b_sel_two_in
    |=> buck_b_auto_out == $past(set_b2_r[MODE_BIT]))
    else $error("buck b mode not from setting two");

  forced_pwm_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    opm_a_r == OPM_PWM ##1 opm_a_r == OPM_PWM |-> !buck_a_auto_out)
    else $error("buck a not in pwm when forced");

  map_two_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    !four_wire_in && page_r[2:1] == PG2_P2 && !addr_in[7]
    |-> addr_hit && full_addr == (BASE_P2 | {3'h0, addr_in[6:0]}))
    else $error("two-wire page mapping wrong");

  map_four_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    four_wire_in && page_r == PG4_HIGH
    |-> addr_hit && full_addr == (BASE_HIGH | {3'h0, addr_in[6:0]}))
    else $error("four-wire page mapping wrong");

  follow_sel_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n)
    $changed(buck_b_sel_two_in) && lim_loaded_r
    |=> buck_b_vcode_out == clamp_code(($past(buck_b_sel_two_in)
          ? $past(set_b2_r[CODE_W-1:0]) : $past(set_b1_r[CODE_W-1:0])),
          lim_b_r))
    else $error("buck b output did not follow selection");

endmodule // bvp_regs

`default_nettype wire

// ===== bvp_host.sv
// host model: byte accesses into the register bank and end strobes
// assumes the bank samples requests on the rising edge of clk_in
`timescale 1ns/1ps
`default_nettype none

module bvp_host (
  // clock
  input  wire logic       clk_in,
  // access request
  output var  logic [7:0] addr_out,
  output var  logic       wr_en_out,
  output var  logic [7:0] wr_data_out,
  output var  logic       rd_en_out,
  output var  logic       done_out,
  // read answer
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in
);
  // idle bus at time zero
  initial begin
    addr_out    = 8'h00;
    wr_en_out   = 1'b0;
    wr_data_out = 8'h00;
    rd_en_out   = 1'b0;
    done_out    = 1'b0;
  end

  // released lines show the inverse, so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out    <= a;
    wr_data_out <= d;
    wr_en_out   <= 1'b1;
    @(posedge clk_in);
    wr_en_out   <= 1'b0;
    addr_out    <= ~a;
    wr_data_out <= ~d;
  endtask

  // answer stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk_in);
    addr_out  <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    addr_out  <= ~a;
    #1;
    d = rd_data_in;
    v = rd_valid_in;
  endtask

  // one-cycle end of transaction
  task automatic done();
    @(posedge clk_in);
    done_out <= 1'b1;
    @(posedge clk_in);
    done_out <= 1'b0;
  endtask
endmodule // bvp_host
`default_nettype wire

// ===== bvp_regs_test.sv
// self-checking bench for the buck voltage and page register bank
// assumes page control also answers at in-page address 0x00 of page 0
`timescale 1ns/1ps
`default_nettype none

module bvp_regs_test;
  localparam logic [6:0] LIM_A = 7'h50;  // factory limits, arbitrary
  localparam logic [6:0] LIM_B = 7'h40;
  logic       ref_clk, nrst, four_wire, test_mode, sel_a, sel_b;
  logic       wr_en, rd_en, done, rd_valid, wmode, aa, ab;
  logic [7:0] addr, wr_data, rd_data;
  logic [2:0] page_sel;
  logic [6:0] va, vb;
  logic [10:0] ma, mb;
  int         n_mismatch = 0;
  int         samples_checked = 0;

  bvp_host u_host (.clk_in(ref_clk), .addr_out(addr), .wr_en_out(wr_en),
    .wr_data_out(wr_data), .rd_en_out(rd_en), .done_out(done),
    .rd_data_in(rd_data), .rd_valid_in(rd_valid));

  bvp_regs u_dut (.ref_clk_in(ref_clk), .nrst_in(nrst),
    .four_wire_in(four_wire), .addr_in(addr), .wr_en_in(wr_en),
    .wr_data_in(wr_data), .rd_en_in(rd_en), .xfer_done_in(done),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .page_sel_out(page_sel), .write_mode_out(wmode),
    .otp_limit_a_in(LIM_A), .otp_limit_b_in(LIM_B),
    .test_mode_in(test_mode), .buck_a_sel_two_in(sel_a),
    .buck_b_sel_two_in(sel_b), .buck_a_vcode_out(va),
    .buck_a_auto_out(aa), .buck_a_mv_out(ma), .buck_b_vcode_out(vb),
    .buck_b_auto_out(ab), .buck_b_mv_out(mb));

  // 200 MHz
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [10:0] mv(input logic [6:0] c);
    return 11'h12C + 11'(c) * 11'h00A;
  endfunction

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    u_host.rd(a, d, v);
    chk(11'(v), 11'h001);
    chk(11'(d), 11'(e));
  endtask

  // regulator outputs are registered, so let two edges pass
  task automatic outs(input logic [6:0] ca, input logic xa,
                      input logic [6:0] cb, input logic xb);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(11'(va), 11'(ca));
    chk(11'(aa), 11'(xa));
    chk(ma, mv(ca));
    chk(11'(vb), 11'(cb));
    chk(11'(ab), 11'(xb));
    chk(mb, mv(cb));
  endtask

  task automatic pg(input logic [2:0] p, input logic w);
    @(posedge ref_clk);
    #1;
    chk(11'(page_sel), 11'(p));
    chk(11'(wmode), 11'(w));
  endtask

  task automatic sel(input logic a, input logic b);
    @(posedge ref_clk);
    sel_a <= a;
    sel_b <= b;
  endtask

  task automatic t_settings();
    outs(7'h00, 1'b0, 7'h00, 1'b0);
    rchk(8'hD7, 8'h00);
    u_host.wr(8'hD7, 8'h85);
    u_host.wr(8'hD8, 8'h7F);
    u_host.wr(8'hD9, 8'h3A);
    u_host.wr(8'hDA, 8'hFF);
    outs(7'h05, 1'b1, 7'h3A, 1'b0);
    sel(1'b1, 1'b1);
    outs(LIM_A, 1'b0, LIM_B, 1'b1);
    rchk(8'hD8, 8'h7F);
    rchk(8'hDA, 8'hFF);
  endtask

  task automatic t_limits();
    rchk(8'hD6, 8'h00);
    @(posedge ref_clk);
    test_mode <= 1'b1;
    rchk(8'hD6, {1'b0, LIM_B});
    rchk(8'hD5, {1'b0, LIM_A});
    u_host.wr(8'hD6, 8'h7F);
    rchk(8'hD6, {1'b0, LIM_B});
    @(posedge ref_clk);
    test_mode <= 1'b0;
    outs(LIM_A, 1'b0, LIM_B, 1'b1);
  endtask

  // setting two of buck A has PWM bit, of buck B the automatic bit
  task automatic t_opmode();
    logic [1:0] m;
    for (int i = 3; i >= 0; i--) begin
      m = 2'(i);
      u_host.wr(8'hD1, {6'h3F, m});
      u_host.wr(8'hD2, {6'h3F, m});
      outs(LIM_A, (m == 2'h1) || (m == 2'h3), LIM_B, m != 2'h2);
      rchk(8'hD1, {6'h00, m});
    end
  endtask

  task automatic t_page();
    u_host.wr(8'h00, 8'h43);
    pg(3'h3, 1'b1);
    rchk(8'h00, 8'h43);
    rchk(8'hD7, 8'h00);
    u_host.wr(8'h00, 8'h84);
    pg(3'h4, 1'b0);
    rchk(8'h57, 8'h00);
    u_host.done();
    pg(3'h0, 1'b0);
    rchk(8'hD7, 8'h85);
    u_host.wr(8'h00, 8'h02);
    u_host.done();
    pg(3'h2, 1'b0);
    u_host.wr(8'h00, 8'h00);
    @(posedge ref_clk);
    four_wire <= 1'b1;
    u_host.wr(8'h00, 8'h82);
    rchk(8'h00, 8'h82);
    u_host.done();
    pg(3'h0, 1'b0);
    u_host.wr(8'h00, 8'h81);
    rchk(8'h57, 8'h85);
    rchk(8'hD7, 8'h85);
    u_host.done();
    rchk(8'h57, 8'h00);
    @(posedge ref_clk);
    four_wire <= 1'b0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // guard against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    nrst      = 1'b0;
    four_wire = 1'b0;
    test_mode = 1'b0;
    sel_a     = 1'b0;
    sel_b     = 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    t_settings();
    t_limits();
    t_opmode();
    t_page();
    test_done();
  end
endmodule // bvp_regs_test
`default_nettype wire
